// [shared/tmd_pkg.sv]
// shared constants for the transport move decoder
package tmd_pkg;
  localparam int DW = 16;
  localparam int ACC_N = 16;
  localparam int STK_DEPTH = 16;
  // module specifiers
  localparam logic [3:0] PERIPH_LAST = 4'h5;
  localparam logic [3:0] AP_MOD = 4'h8;
  localparam logic [3:0] ACC_MOD = 4'h9;
  localparam logic [3:0] ALU_MOD = 4'hA;
  localparam logic [3:0] PFX_MOD = 4'hB;
  localparam logic [3:0] STK_MOD = 4'hD;
  localparam logic [3:0] MEM_MOD = 4'hE;
  localparam logic [3:0] PTR_MOD = 4'hF;
  // register indices inside the internal modules
  localparam logic [4:0] AP_IDX = 5'h00;
  localparam logic [4:0] FLG_IDX = 5'h04;
  localparam logic [4:0] PFX_IDX = 5'h00;
  localparam logic [4:0] STK_IDX = 5'h01;
  localparam logic [4:0] DP0_IDX = 5'h00;
  localparam logic [4:0] DP1_IDX = 5'h01;
  localparam logic [4:0] BP_IDX = 5'h02;
  localparam logic [4:0] FRAME_OFFSET_REGISTER_IDX = 5'h03;
  // memory access field: [1:0] pointer select, [3:2] step mode
  localparam logic [1:0] PSEL_DP0 = 2'h0;
  localparam logic [1:0] PSEL_DP1 = 2'h1;
  localparam logic [1:0] PSEL_FP = 2'h2;
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_INC = 2'h1;
  localparam logic [1:0] MODE_DEC = 2'h2;
  // alu operations selected by destination subindex in ALU_MOD
  localparam logic [2:0] OP_ADD = 3'h0;
  localparam logic [2:0] OP_SUB = 3'h1;
  localparam logic [2:0] OP_AND = 3'h2;
  localparam logic [2:0] OP_OR = 3'h3;
  localparam logic [2:0] OP_XOR = 3'h4;
  // status flag positions
  localparam int FLG_ZERO = 0;
  localparam int FLG_EQ = 1;
  localparam int FLG_CARRY = 2;
  localparam int FLG_SIGN = 3;
  localparam int FLG_OVF = 4;
  // reset values
  localparam logic [15:0] RST_W = 16'h0000;
  localparam logic [7:0] RST_B = 8'h00;
endpackage

// [shared/tmd_stk_if.sv]
// push/pop port between the decoder and its hardware stack
`timescale 1ns/10ps
interface tmd_stk_if;
  logic push;
  logic pop;
  logic [15:0] wdata;
  logic [15:0] top;
  modport ctl (output push, output pop, output wdata, input top);
  modport mem (input push, input pop, input wdata, output top);
endinterface

// [core/tmd_stack.sv]
// dedicated word-wide hardware stack
`timescale 1ns/10ps
module tmd_stack import tmd_pkg::*; #(
  parameter int DEPTH = STK_DEPTH
) (
  input wire logic clk,
  input wire logic srst,
  tmd_stk_if.mem stk
);
  localparam int AW = $clog2(DEPTH);
  logic [AW-1:0] sp_ff, nxt_sp;
  logic [15:0] mem_ff [DEPTH];
  logic [15:0] nxt_mem [DEPTH];

  assign stk.top = mem_ff[sp_ff];

  // pointer wraps silently; overflow is software's problem, as on the core
  always_comb begin
    nxt_sp = sp_ff;
    nxt_mem = mem_ff;
    if (stk.push && stk.pop) begin
      nxt_mem[sp_ff] = stk.wdata;
    end else if (stk.push) begin
      nxt_sp = sp_ff + AW'(1);
      nxt_mem[nxt_sp] = stk.wdata;
    end else if (stk.pop) begin
      nxt_sp = sp_ff - AW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sp_ff <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= RST_W;
      end
    end else begin
      sp_ff <= nxt_sp;
      mem_ff <= nxt_mem;
    end
  end

  chk_push_lands: assert property (@(posedge clk) disable iff (srst)
    stk.push && !stk.pop |=> stk.top == $past(stk.wdata))
    else $error("pushed word is not on top of stack");
endmodule

// [core/tmd_decoder.sv]
// single-cycle instruction decoder and register transport core
`timescale 1ns/10ps
module tmd_decoder import tmd_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic instr_en,
  input wire logic [15:0] instr,
  input wire logic [15:0] ext_rd_data,
  input wire logic ext_src_defined,
  input wire logic ext_src_wide,
  input wire logic ext_src_mod8,
  input wire logic ext_dst_defined,
  input wire logic ext_dst_wide,
  input wire logic [15:0] mem_rd_data,
  output logic [7:0] pfx_val_ff,
  output logic [2:0] pfx_idx_ff,
  output logic wr_en_ff,
  output logic [3:0] wr_mod_ff,
  output logic [4:0] wr_idx_ff,
  output logic [15:0] wr_data_ff,
  output logic periph_ff,
  output logic bit_addr_ff,
  output logic [15:0] dp0_ff,
  output logic [15:0] dp1_ff,
  output logic [15:0] bp_ff,
  output logic [7:0] frame_offset_register_ff,
  output logic [15:0] fp_addr_ff,
  output logic mem_wr_en_ff,
  output logic [15:0] mem_wr_addr_ff,
  output logic [15:0] mem_wr_data_ff,
  output logic [4:0] flags_ff
);
  ////////////////////////////////////////////////////////////////////////////
  logic ex, imm;
  logic [3:0] s_mod, d_mod, ap_ff, nxt_ap;
  logic [4:0] s_idx, d_idx, nxt_flags;
  logic [15:0] s_val, src16, wdata, alu_res, wa;
  logic s_def, s_wide, s_m8, s_mem;
  logic d_def, d_wide, d_ext, d_mem, alu_go, pfx_wr, ap_wr, acc_wr, ptr_wr;
  logic [15:0] acc_ff [ACC_N];
  logic [15:0] nxt_acc [ACC_N];
  logic [7:0] nxt_pfx_val, nxt_frame_offset_register;
  logic [2:0] nxt_pfx_idx;
  logic nxt_wr_en, nxt_periph, nxt_bit_addr, nxt_mem_wr_en;
  logic [15:0] nxt_dp0, nxt_dp1, nxt_bp, nxt_fp_addr;
  tmd_stk_if stk ();
  tmd_stack #(.DEPTH(STK_DEPTH)) u_stack (
    .clk(clk),
    .srst(srst),
    .stk(stk)
  );
  function automatic logic [15:0] step16(input logic [15:0] v, input logic [1:0] m);
    step16 = (m == MODE_INC) ? v + 16'h0001 : (m == MODE_DEC) ? v - 16'h0001 : v;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // field split; the prefix carries the upper index bits
  assign ex = instr_en;
  assign imm = !instr[15];
  assign s_mod = instr[3:0];
  assign s_idx = {pfx_idx_ff[2], instr[7:4]};
  assign d_mod = instr[11:8];
  assign d_idx = {pfx_idx_ff[1:0], instr[14:12]};
  always_comb begin
    s_def = 1'b1;
    s_wide = 1'b1;
    s_m8 = 1'b0;
    s_mem = 1'b0;
    s_val = RST_W;
    stk.pop = 1'b0;
    if (imm) begin
      s_val = {8'h00, instr[7:0]};
      s_wide = 1'b0;
    end else begin
      case (s_mod)
        AP_MOD: begin
          s_m8 = 1'b1;
          s_wide = 1'b0;
          if (s_idx == AP_IDX) s_val = {12'h000, ap_ff};
          else if (s_idx == FLG_IDX) s_val = {11'h000, flags_ff};
          else s_def = 1'b0;
        end
        ACC_MOD: begin
          if (!s_idx[4]) s_val = acc_ff[s_idx[3:0]];
          else s_def = 1'b0;
        end
        PFX_MOD: begin
          s_m8 = 1'b1;
          s_wide = 1'b0;
          if (s_idx == PFX_IDX) s_val = {8'h00, pfx_val_ff};
          else s_def = 1'b0;
        end
        STK_MOD: begin
          if (s_idx == STK_IDX) begin
            s_val = stk.top;
            stk.pop = ex;
          end else s_def = 1'b0;
        end
        MEM_MOD: begin
          if (!s_idx[4] && s_idx[1:0] != 2'h3 && s_idx[3:2] != 2'h3) begin
            s_val = mem_rd_data;
            s_mem = 1'b1;
          end else s_def = 1'b0;
        end
        PTR_MOD: begin
          s_m8 = 1'b1;
          if (s_idx == DP0_IDX) s_val = dp0_ff;
          else if (s_idx == DP1_IDX) s_val = dp1_ff;
          else if (s_idx == BP_IDX) s_val = bp_ff;
          else if (s_idx == FRAME_OFFSET_REGISTER_IDX) begin
            s_val = {8'h00, frame_offset_register_ff};
            s_wide = 1'b0;
          end else s_def = 1'b0;
        end
        ALU_MOD: s_def = 1'b0;
        default: begin
          s_val = ext_rd_data;
          s_def = ext_src_defined;
          s_wide = ext_src_wide;
          s_m8 = ext_src_mod8;
        end
      endcase
      if (!s_def) begin
        s_val = s_m8 ? {pfx_val_ff, 8'h00} : 16'h0000;
        s_wide = 1'b1;
      end
    end
  end
  assign src16 = s_wide ? s_val : {pfx_val_ff, s_val[7:0]};
  assign wdata = d_wide ? src16 : {8'h00, s_val[7:0]};
  ////////////////////////////////////////////////////////////////////////////
  // destination decode; empty locations 0 to 4 in ALU_MOD trigger operations
  always_comb begin
    d_def = 1'b0;
    d_wide = 1'b1;
    d_ext = 1'b0;
    d_mem = 1'b0;
    alu_go = 1'b0;
    pfx_wr = 1'b0;
    ap_wr = 1'b0;
    acc_wr = 1'b0;
    ptr_wr = 1'b0;
    stk.push = 1'b0;
    case (d_mod)
      AP_MOD: begin
        d_wide = 1'b0;
        ap_wr = (d_idx == AP_IDX);
        d_def = ap_wr;
      end
      ACC_MOD: begin
        acc_wr = !d_idx[4];
        d_def = acc_wr;
      end
      ALU_MOD: alu_go = (d_idx <= {2'h0, OP_XOR});
      PFX_MOD: begin
        d_wide = 1'b0;
        pfx_wr = (d_idx < 5'h08);
        d_def = pfx_wr;
      end
      STK_MOD: begin
        stk.push = ex && (d_idx == STK_IDX);
        d_def = (d_idx == STK_IDX);
      end
      MEM_MOD: begin
        d_mem = !d_idx[4] && d_idx[1:0] != 2'h3 && d_idx[3:2] != 2'h3;
        d_def = d_mem;
      end
      PTR_MOD: begin
        ptr_wr = (d_idx <= FRAME_OFFSET_REGISTER_IDX);
        d_def = ptr_wr;
        d_wide = (d_idx != FRAME_OFFSET_REGISTER_IDX);
      end
      default: begin
        d_ext = 1'b1;
        d_def = ext_dst_defined;
        d_wide = ext_dst_wide;
      end
    endcase
  end
  assign stk.wdata = wdata;
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [16:0] r;
    logic [15:0] a;
    r = 17'h00000;
    a = acc_ff[ap_ff];
    nxt_flags = flags_ff;
    case (d_idx[2:0])
      OP_ADD: r = {1'b0, a} + {1'b0, src16};
      OP_SUB: r = {1'b0, a} - {1'b0, src16};
      OP_AND: r = {flags_ff[FLG_CARRY], a & src16};
      OP_OR: r = {flags_ff[FLG_CARRY], a | src16};
      default: r = {flags_ff[FLG_CARRY], a ^ src16};
    endcase
    alu_res = r[15:0];
    if (ex && alu_go) begin
      nxt_flags[FLG_ZERO] = (r[15:0] == 16'h0000);
      nxt_flags[FLG_EQ] = (a == src16);
      nxt_flags[FLG_CARRY] = r[16];
      nxt_flags[FLG_SIGN] = r[15];
      nxt_flags[FLG_OVF] = 1'b0;
      if (d_idx[2:0] == OP_ADD) nxt_flags[FLG_OVF] = (a[15] == src16[15]) && (r[15] != a[15]);
      if (d_idx[2:0] == OP_SUB) nxt_flags[FLG_OVF] = (a[15] != src16[15]) && (r[15] != a[15]);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_dp0 = dp0_ff;
    nxt_dp1 = dp1_ff;
    nxt_bp = bp_ff;
    nxt_frame_offset_register = frame_offset_register_ff;
    nxt_acc = acc_ff;
    nxt_ap = ap_ff;
    // source side effects happen even when the destination is undefined
    if (ex && s_mem) begin
      case (s_idx[1:0])
        PSEL_DP0: nxt_dp0 = step16(nxt_dp0, s_idx[3:2]);
        PSEL_DP1: nxt_dp1 = step16(nxt_dp1, s_idx[3:2]);
        default: nxt_frame_offset_register = 8'(step16({8'h00, nxt_frame_offset_register}, s_idx[3:2]));
      endcase
    end
    if (ex && d_mem) begin
      case (d_idx[1:0])
        PSEL_DP0: nxt_dp0 = step16(nxt_dp0, d_idx[3:2]);
        PSEL_DP1: nxt_dp1 = step16(nxt_dp1, d_idx[3:2]);
        default: nxt_frame_offset_register = 8'(step16({8'h00, nxt_frame_offset_register}, d_idx[3:2]));
      endcase
    end
    if (ex && ptr_wr) begin
      if (d_idx == DP0_IDX) nxt_dp0 = wdata;
      else if (d_idx == DP1_IDX) nxt_dp1 = wdata;
      else if (d_idx == BP_IDX) nxt_bp = wdata;
      else nxt_frame_offset_register = wdata[7:0];
    end
    nxt_fp_addr = nxt_bp + {8'h00, nxt_frame_offset_register};
    wa = (d_idx[1:0] == PSEL_DP0) ? nxt_dp0 : (d_idx[1:0] == PSEL_DP1) ? nxt_dp1 : nxt_fp_addr;
    if (ex && acc_wr) nxt_acc[d_idx[3:0]] = wdata;
    if (ex && alu_go) nxt_acc[ap_ff] = alu_res;
    if (ex && ap_wr) nxt_ap = wdata[3:0];
    nxt_pfx_val = (ex && pfx_wr) ? wdata[7:0] : RST_B;
    nxt_pfx_idx = (ex && pfx_wr) ? d_idx[2:0] : 3'h0;
    nxt_wr_en = ex && d_ext && d_def;
    nxt_periph = (d_mod <= PERIPH_LAST);
    nxt_bit_addr = nxt_periph || (d_mod == AP_MOD);
    nxt_mem_wr_en = ex && d_mem;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      dp0_ff <= RST_W;
      dp1_ff <= RST_W;
      bp_ff <= RST_W;
      frame_offset_register_ff <= RST_B;
      fp_addr_ff <= RST_W;
      ap_ff <= 4'h0;
      flags_ff <= 5'h00;
      pfx_val_ff <= RST_B;
      pfx_idx_ff <= 3'h0;
      wr_en_ff <= 1'b0;
      wr_mod_ff <= 4'h0;
      wr_idx_ff <= 5'h00;
      wr_data_ff <= RST_W;
      periph_ff <= 1'b0;
      bit_addr_ff <= 1'b0;
      mem_wr_en_ff <= 1'b0;
      mem_wr_addr_ff <= RST_W;
      mem_wr_data_ff <= RST_W;
      for (int i = 0; i < ACC_N; i++) begin
        acc_ff[i] <= RST_W;
      end
    end else begin
      dp0_ff <= nxt_dp0;
      dp1_ff <= nxt_dp1;
      bp_ff <= nxt_bp;
      frame_offset_register_ff <= nxt_frame_offset_register;
      fp_addr_ff <= nxt_fp_addr;
      ap_ff <= nxt_ap;
      flags_ff <= nxt_flags;
      acc_ff <= nxt_acc;
      pfx_val_ff <= nxt_pfx_val;
      pfx_idx_ff <= nxt_pfx_idx;
      wr_en_ff <= nxt_wr_en;
      wr_mod_ff <= d_mod;
      wr_idx_ff <= d_idx;
      wr_data_ff <= wdata;
      periph_ff <= nxt_periph;
      bit_addr_ff <= nxt_bit_addr;
      mem_wr_en_ff <= nxt_mem_wr_en;
      mem_wr_addr_ff <= wa;
      mem_wr_data_ff <= wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  chk_pfx_clear: assert property (@(posedge clk) disable iff (srst)
    !(ex && pfx_wr) |=> pfx_val_ff == 8'h00 && pfx_idx_ff == 3'h0) else $error("prefix survived past one cycle");
  chk_narrow_dst: assert property (@(posedge clk) disable iff (srst)
    ex && d_ext && d_def && !d_wide |=> wr_en_ff && wr_data_ff[15:8] == 8'h00)
    else $error("narrow destination got a high byte");
  chk_wide_fill: assert property (@(posedge clk) disable iff (srst)
    ex && d_ext && d_def && d_wide && !s_wide |=> wr_data_ff[15:8] == $past(pfx_val_ff))
    else $error("high byte not taken from prefix");
  chk_undef_dst: assert property (@(posedge clk) disable iff (srst)
    ex && d_ext && !d_def |=> !wr_en_ff) else $error("undefined destination was written");
  chk_post_inc: assert property (@(posedge clk) disable iff (srst)
    ex && s_mem && s_idx[1:0] == PSEL_DP0 && s_idx[3:2] == MODE_INC && !d_mem && !ptr_wr
    |=> dp0_ff == $past(dp0_ff) + 16'h0001) else $error("pointer post-increment missing");
  chk_fp_base: assert property (@(posedge clk) disable iff (srst)
    ex && (s_mem || d_mem) && !ptr_wr |=> $stable(bp_ff) && fp_addr_ff == bp_ff + {8'h00, frame_offset_register_ff})
    else $error("frame step disturbed the base");
  chk_periph_sel: assert property (@(posedge clk) disable iff (srst)
    ex |=> periph_ff == ($past(instr[11:8]) <= PERIPH_LAST) && bit_addr_ff == (periph_ff || wr_mod_ff == AP_MOD))
    else $error("peripheral group flag wrong");
  chk_pfx_index: assert property (@(posedge clk) disable iff (srst)
    ex && d_ext |=> wr_idx_ff[4:3] == $past(pfx_idx_ff[1:0])) else $error("destination index lost prefix bits");
  chk_undef_src: assert property (@(posedge clk) disable iff (srst)
    ex && !imm && !s_def && s_m8 && d_ext && d_def && d_wide |=> wr_data_ff == {$past(pfx_val_ff), 8'h00})
    else $error("undefined byte-module source value wrong");
endmodule

// [tb/tmd_reg_model.sv]
// behavioural model of the external register modules and the data memory
`timescale 1ns/10ps
module tmd_reg_model (
  input wire logic [15:0] instr,
  input wire logic [15:0] dp0_ff,
  input wire logic [15:0] dp1_ff,
  input wire logic [15:0] fp_addr_ff,
  output logic [15:0] ext_rd_data,
  output logic ext_src_defined,
  output logic ext_src_wide,
  output logic ext_src_mod8,
  output logic ext_dst_defined,
  output logic ext_dst_wide,
  output logic [15:0] mem_rd_data
);
  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] smod;
  logic [3:0] sidx;
  logic [15:0] maddr;
  // odd modules hold word registers, even ones byte registers, in any group
  always_comb begin
    smod = instr[3:0];
    sidx = instr[7:4];
    ext_src_defined = (sidx < 4'h8);
    ext_src_wide = smod[0];
    ext_src_mod8 = ~smod[0];
    // undefined places return junk so that the decoder must ignore it
    ext_rd_data = !ext_src_defined ? 16'hC3C3 : ext_src_wide ? {smod, sidx, ~smod, ~sidx} : {8'h00, sidx, ~smod};
    ext_dst_defined = (instr[14:12] != 3'h7);
    ext_dst_wide = instr[8];
  end
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    maddr = (instr[5:4] == 2'h0) ? dp0_ff : (instr[5:4] == 2'h1) ? dp1_ff : fp_addr_ff;
    mem_rd_data = maddr ^ 16'hA5A5;
  end
endmodule

// [tb/transport_move_decoder_tb_top.sv]
// self-checking bench for the transport move decoder
`timescale 1ns/10ps
module transport_move_decoder_tb_top import tmd_pkg::*; ;
  int fail_count = 0;
  int check_count = 0;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic instr_en = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [15:0] ext_rd_data, mem_rd_data;
  logic ext_src_defined, ext_src_wide, ext_src_mod8, ext_dst_defined, ext_dst_wide;
  logic [7:0] pfx_val_ff, frame_offset_register_ff;
  logic [2:0] pfx_idx_ff;
  logic wr_en_ff, periph_ff, bit_addr_ff, mem_wr_en_ff;
  logic [3:0] wr_mod_ff;
  logic [4:0] wr_idx_ff, flags_ff;
  logic [15:0] wr_data_ff, dp0_ff, dp1_ff, bp_ff, fp_addr_ff, mem_wr_addr_ff, mem_wr_data_ff;
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  tmd_decoder i_tmd_decoder (
    .clk(clk), .srst(srst), .instr_en(instr_en), .instr(instr), .ext_rd_data(ext_rd_data),
    .ext_src_defined(ext_src_defined), .ext_src_wide(ext_src_wide), .ext_src_mod8(ext_src_mod8),
    .ext_dst_defined(ext_dst_defined), .ext_dst_wide(ext_dst_wide), .mem_rd_data(mem_rd_data),
    .pfx_val_ff(pfx_val_ff), .pfx_idx_ff(pfx_idx_ff), .wr_en_ff(wr_en_ff), .wr_mod_ff(wr_mod_ff),
    .wr_idx_ff(wr_idx_ff), .wr_data_ff(wr_data_ff), .periph_ff(periph_ff), .bit_addr_ff(bit_addr_ff),
    .dp0_ff(dp0_ff), .dp1_ff(dp1_ff), .bp_ff(bp_ff), .frame_offset_register_ff(frame_offset_register_ff), .fp_addr_ff(fp_addr_ff),
    .mem_wr_en_ff(mem_wr_en_ff), .mem_wr_addr_ff(mem_wr_addr_ff), .mem_wr_data_ff(mem_wr_data_ff),
    .flags_ff(flags_ff)
  );
  tmd_reg_model i_tmd_reg_model (
    .instr(instr), .dp0_ff(dp0_ff), .dp1_ff(dp1_ff), .fp_addr_ff(fp_addr_ff), .ext_rd_data(ext_rd_data),
    .ext_src_defined(ext_src_defined), .ext_src_wide(ext_src_wide), .ext_src_mod8(ext_src_mod8),
    .ext_dst_defined(ext_dst_defined), .ext_dst_wide(ext_dst_wide), .mem_rd_data(mem_rd_data)
  );
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] imm(input logic [2:0] s, input logic [3:0] d, input logic [7:0] v);
    return {1'b0, s, d, v};
  endfunction
  function automatic logic [15:0] rmv(input logic [2:0] s, input logic [3:0] d, input logic [3:0] si,
                                      input logic [3:0] sm);
    return {1'b1, s, d, si, sm};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // instruction is presented after an edge and taken at the next one
  task automatic ex(input logic [15:0] v);
    @(posedge clk);
    instr <= v;
    instr_en <= 1'b1;
  endtask
  // lets the last instruction execute, then settles its results
  task automatic fin;
    @(posedge clk);
    instr_en <= 1'b0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(16'({wr_en_ff, mem_wr_en_ff}), 16'h0000, "reset strobes");
    chk(dp0_ff | dp1_ff | bp_ff, 16'h0000, "reset pointers");
    chk(16'({pfx_val_ff, flags_ff}), 16'h0000, "reset prefix and flags");
    $display("t_reset done");
  endtask
  task automatic t_moves;
    ex(imm(3'h2, 4'h1, 8'h5C));
    fin;
    chk(16'(wr_en_ff), 16'h0001, "imm write");
    chk(wr_data_ff, 16'h005C, "imm data");
    chk(16'({wr_mod_ff, wr_idx_ff}), 16'h0022, "imm dst");
    ex(rmv(3'h4, 4'h6, 4'h4, 4'h3));
    ex(rmv(3'h0, 4'h1, 4'h4, 4'h3));
    #1;
    chk(wr_data_ff, 16'h00CB, "wide to narrow");
    chk(16'({wr_mod_ff, wr_idx_ff}), 16'h00C4, "narrow dst");
    chk(16'({periph_ff, bit_addr_ff}), 16'h0000, "system dst");
    ex(rmv(3'h0, 4'h6, 4'h3, 4'h2));
    #1;
    chk(wr_data_ff, 16'h34CB, "wide copy");
    ex(imm(3'h0, 4'h5, 8'h01));
    #1;
    chk(wr_data_ff, 16'h003D, "narrow copy");
    ex(imm(3'h0, AP_MOD, 8'h00));
    #1;
    chk(16'({periph_ff, bit_addr_ff}), 16'h0003, "last peripheral");
    fin;
    chk(16'({periph_ff, bit_addr_ff}), 16'h0001, "pointer module");
    $display("t_moves done");
  endtask
  task automatic t_prefix;
    ex(imm(3'h1, PFX_MOD, 8'h12));
    ex(rmv(3'h5, 4'h1, 4'h3, 4'h2));
    #1;
    chk(16'({pfx_idx_ff, pfx_val_ff}), 16'h0112, "prefix held");
    fin;
    chk(16'(wr_idx_ff), 16'h000D, "upper dst index");
    chk(wr_data_ff, 16'h123D, "prefix high byte");
    chk(16'(pfx_val_ff), 16'h0000, "prefix cleared");
    ex(imm(3'h1, PFX_MOD, 8'h12));
    fin;
    ex(rmv(3'h5, 4'h1, 4'h3, 4'h2));
    fin;
    chk(16'(wr_idx_ff), 16'h0005, "idle drops index");
    chk(wr_data_ff, 16'h003D, "idle drops value");
    $display("t_prefix done");
  endtask
  task automatic t_undef;
    ex(imm(3'h0, PTR_MOD, 8'h10));
    ex(rmv(3'h7, 4'h2, 4'h4, MEM_MOD));
    fin;
    chk(16'(wr_en_ff), 16'h0000, "no store");
    chk(dp0_ff, 16'h0011, "side effect kept");
    ex(rmv(3'h0, 4'h1, 4'h9, 4'h4));
    ex(imm(3'h0, PFX_MOD, 8'h34));
    #1;
    chk(wr_data_ff, 16'h0000, "undefined byte src");
    ex(rmv(3'h0, 4'h1, 4'h9, 4'h4));
    ex(imm(3'h0, PFX_MOD, 8'h34));
    #1;
    chk(wr_data_ff, 16'h3400, "undefined byte src prefixed");
    ex(rmv(3'h0, 4'h1, 4'h9, 4'h5));
    fin;
    chk(wr_data_ff, 16'h0000, "undefined word src");
    $display("t_undef done");
  endtask
  task automatic t_pointers;
    ex(rmv(3'h0, 4'h1, 4'h4, MEM_MOD));
    fin;
    chk(wr_data_ff, 16'hA5B4, "post-inc read");
    chk(dp0_ff, 16'h0012, "post-inc step");
    ex(imm(3'h5, MEM_MOD, 8'h77));
    fin;
    chk(16'(mem_wr_en_ff), 16'h0001, "mem write");
    chk(mem_wr_addr_ff ^ mem_wr_data_ff, 16'h0076, "pre-inc write");
    chk(dp1_ff, 16'h0001, "pre-inc pointer");
    ex(imm(3'h1, PFX_MOD, 8'h00));
    ex(imm(3'h0, MEM_MOD, 8'h99));
    fin;
    chk(mem_wr_addr_ff, 16'h0011, "pre-dec write");
    chk(dp0_ff, 16'h0011, "pre-dec step");
    ex(imm(3'h0, PFX_MOD, 8'h12));
    ex(imm(3'h2, PTR_MOD, 8'h40));
    ex(imm(3'h3, PTR_MOD, 8'hFF));
    ex(imm(3'h6, MEM_MOD, 8'h21));
    fin;
    chk(16'(mem_wr_en_ff), 16'h0001, "frame write");
    chk(mem_wr_addr_ff, 16'h1240, "frame pre-inc");
    chk(bp_ff ^ 16'(frame_offset_register_ff), 16'h1240, "offset wraps alone");
    fin;
    chk(16'(mem_wr_en_ff), 16'h0000, "single pulse");
    chk(fp_addr_ff, 16'h1240, "frame address");
    ex(rmv(3'h0, 4'h1, 4'hA, MEM_MOD));
    fin;
    chk(wr_data_ff, 16'hB7E5, "frame post-dec read");
    chk(16'(frame_offset_register_ff), 16'h00FF, "offset steps down");
    chk(bp_ff, 16'h1240, "base untouched");
    $display("t_pointers done");
  endtask
  task automatic t_alu_stack;
    ex(imm(OP_ADD, ALU_MOD, 8'h05));
    ex(rmv(3'h0, 4'h1, 4'h0, ACC_MOD));
    fin;
    chk(wr_data_ff, 16'h0005, "acc sum");
    ex(imm(OP_SUB, ALU_MOD, 8'h05));
    fin;
    chk(16'(flags_ff[FLG_ZERO]), 16'h0001, "zero flag");
    chk(16'(flags_ff), 16'h0003, "sub flags");
    ex(imm(3'h1, STK_MOD, 8'h3C));
    ex(rmv(3'h0, 4'h1, 4'h1, STK_MOD));
    fin;
    chk(wr_data_ff, 16'h003C, "stack pop");
    ex(imm(3'h0, AP_MOD, 8'hF5));
    ex(rmv(3'h0, 4'h1, 4'h0, AP_MOD));
    fin;
    chk(wr_data_ff, 16'h0005, "pointer reads four bits");
    $display("t_alu_stack done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    fin;
    t_reset;
    t_moves;
    t_prefix;
    t_undef;
    t_pointers;
    t_alu_stack;
    close_out;
  end
  // the tests need about 70 cycles, so this leaves wide margin
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out;
  end
endmodule
